/* File: include/clk_ctl_pkg.sv */
// Package of constants and types for the PLL clock control unit.
package clk_ctl_pkg;
  // -----------------------------------------------------------------
  // Register map
  // -----------------------------------------------------------------
  localparam logic [11:0] PLL_CFG_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam logic [11:0] CTRL_OFFSET = 12'h008;
  // -----------------------------------------------------------------
  // Field positions of the PLL configuration register
  // -----------------------------------------------------------------
  localparam int FB_DIV_LSB = 0;
  localparam int FB_DIV_W = 6;
  localparam int MEM_DIV_LSB = 8;
  localparam int MEM_DIV_W = 8;
  localparam int CHANGE_BIT = 16;
  localparam int CHAR_SEL_LSB = 20;
  // Status fields.
  localparam int ST_LOCK_BIT = 0;
  localparam int ST_STABLE_BIT = 1;
  localparam int ST_TEST_BIT = 2;
  localparam int ST_WMR_BIT = 3;
  // Control fields.
  localparam int CTRL_CLAMP_BIT = 0;
  // -----------------------------------------------------------------
  // Reset values and limits
  // -----------------------------------------------------------------
  localparam logic [5:0] FB_DIV_RESET = 6'h07;
  localparam logic [5:0] FB_DIV_MIN = 6'h07;
  localparam logic [7:0] MEM_DIV_RESET = 8'h08;
  localparam logic [31:0] PLL_CFG_RESET = 32'h0000_0807;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;
  // -----------------------------------------------------------------
  // Timing
  // -----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int LOCK_TIME_NS = 100000;
  localparam int LOCK_CYCLES = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REF_DIV = 4;
  // -----------------------------------------------------------------
  // Clock source selection and lock sequencer
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_VCO = 2'h0,
    SRC_REF = 2'h1,
    SRC_BYPASS = 2'h2,
    SRC_STRETCH = 2'h3
  } src_sel_t;
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_LOCKING = 2'b01,
    ST_LOCKED = 2'b11
  } lock_state_t;
endpackage

/* File: design/clk_ctl_unit.sv */
// PLL clock control unit: dividers, source select, test pins, reset handshake.
//
// The implementer's own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
// Contract
// - test-mode pin enables pin-driven controls
// - drive two-bit characterization output
// - test mode takes feedback divider from pins
// - test mode takes memory divider from pins
// - test mode resets PLL from pin
// - test mode passes clamp pin through
// - select picks one of four clock sources
// - stretch clock while stretch input high
// - stop inputs present, no effect
// - PLL held in reset, then locks
// - generate ref/core sync pulses
// - forward buffered reference clock
// - assert stable after lock completes
// - change indication from change field only
// - warm-reset preparation input accepted
// - cluster hold low forces clock low
// - core and memory from independent dividers
// - divide-by-four and two phase signals
// - no fixed reference phase assumed
// - feedback divider is value minus one
module clk_ctl_unit
  import clk_ctl_pkg::*;
#(
  parameter int LOCK_COUNT = LOCK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pll_rst_n,
  input wire logic haddr_sel,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic test_mode_pin,
  input wire logic [5:0] test_feedback_divider_in,
  input wire logic [7:0] test_mem_divider_in,
  input wire logic test_pll_rst_n_pin,
  input wire logic clamp_filter_pin,
  output logic [1:0] pll_char_out,
  output logic pll_clamp_filter,
  input wire logic core_domain_stop,
  input wire logic io_domain_stop,
  input wire logic stop_override,
  input wire logic [1:0] src_select,
  input wire logic core_bypass_clock,
  input wire logic mem_bypass_clock,
  input wire logic clk_stretch,
  input wire logic ref_clock,
  input wire logic wmr_prepare,
  input wire logic cluster_hold_n,
  output logic core_clock_out,
  output logic memory_clock,
  output logic io_phase,
  output logic io_half_rate_clock,
  output logic ref_core_sync,
  output logic core_ref_sync,
  output logic ref_clock_buf,
  output logic sync_stable,
  output logic div_change,
  output logic [5:0] feedback_divider,
  output logic [7:0] mem_divider,
  output logic pll_in_reset
);
  initial begin
    if (LOCK_COUNT < 1) begin
      $error("LOCK_COUNT must be at least one");
    end
  end

  // -----------------------------------------------------------------
  // Pin synchronisers
  // -----------------------------------------------------------------
  // Pins are asynchronous, so every pin except src_select and the unused inputs passes two flops first.
  localparam int PW = 24;
  logic [PW-1:0] pin_raw;
  logic [PW-1:0] pin_s1_q;
  logic [PW-1:0] pin_s2_q;
  assign pin_raw = {test_mode_pin, test_feedback_divider_in, test_mem_divider_in, test_pll_rst_n_pin,
                    clamp_filter_pin, wmr_prepare, cluster_hold_n, ref_clock, mem_bypass_clock,
                    core_bypass_clock, clk_stretch, pll_rst_n};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
    end
  end
  logic test_mode;
  logic [5:0] pin_fb;
  logic [7:0] pin_mem;
  logic pin_trst_n;
  logic pin_clamp;
  logic wmr_s;
  logic hold_n_s;
  logic ref_s;
  logic mem_byp_s;
  logic core_byp_s;
  logic stretch_s;
  logic pll_rst_n_s;
  assign {test_mode, pin_fb, pin_mem, pin_trst_n, pin_clamp, wmr_s, hold_n_s, ref_s, mem_byp_s,
          core_byp_s, stretch_s, pll_rst_n_s} = pin_s2_q;

  // -----------------------------------------------------------------
  // AHB-Lite slave
  // -----------------------------------------------------------------
  logic [31:0] pll_cfg_q;
  logic clamp_sw_q;
  logic wr_pend_q;
  logic [11:0] addr_q;
  logic lock_q;
  logic stable_q;
  logic wmr_q;
  logic accept;
  assign accept = hsel && hready && htrans[1];
  // Address phase is captured; writes land in the data phase, zero wait.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
      addr_q <= 12'h000;
    end else begin
      wr_pend_q <= accept && hwrite;
      if (accept) begin
        addr_q <= haddr[11:0];
      end
    end
  end
  // Configuration and control registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pll_cfg_q <= PLL_CFG_RESET;
      clamp_sw_q <= 1'b0;
    end else if (wr_pend_q) begin
      if (addr_q == PLL_CFG_OFFSET) begin
        pll_cfg_q <= hwdata;
      end else if (addr_q == CTRL_OFFSET) begin
        clamp_sw_q <= hwdata[CTRL_CLAMP_BIT];
      end
    end
  end
  // Read data is registered so hrdata comes from a flop; unmapped reads zero.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= READ_ZERO;
    end else if (accept && !hwrite) begin
      unique case (haddr[11:0])
        PLL_CFG_OFFSET: hrdata <= pll_cfg_q;
        STATUS_OFFSET: hrdata <= {28'h000_0000, wmr_q, test_mode, stable_q, lock_q};
        CTRL_OFFSET: hrdata <= {31'h0000_0000, clamp_sw_q};
        default: hrdata <= READ_ZERO;
      endcase
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // -----------------------------------------------------------------
  // Divider selection
  // -----------------------------------------------------------------
  // Test mode hands the dividers, PLL reset and clamp to the pins.
  logic [5:0] fb_sel;
  logic [7:0] mem_sel;
  logic pll_rst_req;
  always_comb begin
    fb_sel = test_mode ? pin_fb : pll_cfg_q[FB_DIV_LSB +: FB_DIV_W];
    mem_sel = test_mode ? pin_mem : pll_cfg_q[MEM_DIV_LSB +: MEM_DIV_W];
    // Values below the minimum are clamped; field holds divide minus one.
    if (fb_sel < FB_DIV_MIN) begin
      fb_sel = FB_DIV_MIN;
    end
    pll_rst_req = !pll_rst_n_s || (test_mode && !pin_trst_n);
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      feedback_divider <= FB_DIV_RESET;
      mem_divider <= MEM_DIV_RESET;
      pll_clamp_filter <= 1'b0;
      pll_char_out <= 2'b00;
      pll_in_reset <= 1'b1;
    end else begin
      feedback_divider <= fb_sel;
      mem_divider <= mem_sel;
      pll_clamp_filter <= test_mode ? pin_clamp : clamp_sw_q;
      // Meaningful only in test mode; otherwise driven low.
      pll_char_out <= test_mode ? {lock_q, pll_cfg_q[CHAR_SEL_LSB]} : 2'b00;
      pll_in_reset <= pll_rst_req;
    end
  end

  // -----------------------------------------------------------------
  // Lock sequencer
  // -----------------------------------------------------------------
  lock_state_t state_q;
  logic [31:0] lock_cnt_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_RESET;
      lock_cnt_q <= 32'h0000_0000;
    end else if (pll_rst_req) begin
      state_q <= ST_RESET;
      lock_cnt_q <= 32'h0000_0000;
    end else begin
      unique case (state_q)
        ST_RESET: state_q <= ST_LOCKING;
        ST_LOCKING: begin
          lock_cnt_q <= lock_cnt_q + 32'h0000_0001;
          if (lock_cnt_q == 32'(LOCK_COUNT - 1)) begin
            state_q <= ST_LOCKED;
          end
        end
        ST_LOCKED: state_q <= ST_LOCKED;
        default: state_q <= ST_RESET;
      endcase
    end
  end
  // Stable after lock; warm-reset preparation drops it so clocks re-qualify.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_q <= 1'b0;
      stable_q <= 1'b0;
      wmr_q <= 1'b0;
      sync_stable <= 1'b0;
      div_change <= 1'b0;
    end else begin
      lock_q <= state_q == ST_LOCKED;
      stable_q <= lock_q && state_q == ST_LOCKED;
      wmr_q <= wmr_s;
      sync_stable <= stable_q && !wmr_s && !pll_rst_req && state_q == ST_LOCKED;
      div_change <= pll_cfg_q[CHANGE_BIT];
    end
  end

  // -----------------------------------------------------------------
  // Clock generation
  // -----------------------------------------------------------------
  // Core and memory derive from one source through separate counters.
  logic [7:0] core_cnt_q;
  logic [7:0] mem_cnt_q;
  logic [1:0] io_cnt_q;
  logic core_tgl_q;
  logic mem_tgl_q;
  logic core_tick;
  assign core_tick = core_cnt_q == 8'h00;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_cnt_q <= 8'h00;
      core_tgl_q <= 1'b0;
      io_cnt_q <= 2'b00;
    end else begin
      core_cnt_q <= core_tick ? {2'b00, feedback_divider} : core_cnt_q - 8'h01;
      if (core_tick) begin
        core_tgl_q <= !core_tgl_q;
        if (!core_tgl_q) begin
          io_cnt_q <= io_cnt_q + 2'b01;
        end
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_cnt_q <= 8'h00;
      mem_tgl_q <= 1'b0;
    end else if (mem_cnt_q == 8'h00) begin
      mem_cnt_q <= {1'b0, mem_divider[7:1]};
      mem_tgl_q <= !mem_tgl_q;
    end else begin
      mem_cnt_q <= mem_cnt_q - 8'h01;
    end
  end
  // Source mux; core and memory bypass clocks come from the tester.
  logic core_src;
  logic mem_src;
  always_comb begin
    core_src = 1'b0;
    mem_src = 1'b0;
    unique case (src_sel_t'(src_select))
      SRC_VCO: begin
        core_src = core_tgl_q;
        mem_src = mem_tgl_q;
      end
      SRC_REF: begin
        core_src = ref_s;
        mem_src = ref_s;
      end
      SRC_BYPASS: begin
        core_src = core_byp_s;
        mem_src = mem_byp_s;
      end
      SRC_STRETCH: begin
        core_src = core_tgl_q && !stretch_s;
        mem_src = mem_tgl_q && !stretch_s;
      end
    endcase
  end
  // Stop inputs are provisional and deliberately unused.
  // Edges are taken from the internal loop; no phase to the reference is assumed.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_clock_out <= 1'b0;
      memory_clock <= 1'b0;
      io_phase <= 1'b0;
      io_half_rate_clock <= 1'b0;
      ref_clock_buf <= 1'b0;
    end else begin
      core_clock_out <= hold_n_s && core_src;
      memory_clock <= hold_n_s && mem_src;
      io_phase <= hold_n_s && io_cnt_q[1];
      io_half_rate_clock <= hold_n_s && io_cnt_q[0];
      ref_clock_buf <= ref_s;
    end
  end

  // -----------------------------------------------------------------
  // Sync pulses
  // -----------------------------------------------------------------
  // One-cycle pulses on each reference rising and falling edge.
  logic ref_d_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_d_q <= 1'b0;
      ref_core_sync <= 1'b0;
      core_ref_sync <= 1'b0;
    end else begin
      ref_d_q <= ref_s;
      ref_core_sync <= ref_s && !ref_d_q;
      core_ref_sync <= !ref_s && ref_d_q;
    end
  end
endmodule

/* File: bench/clk_ctl_checker.sv */
// Port checker for the PLL clock control unit.
`timescale 1ns/1ps
module clk_ctl_checker
  import clk_ctl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pll_rst_n,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic test_mode_pin,
  input wire logic [5:0] test_feedback_divider_in,
  input wire logic [7:0] test_mem_divider_in,
  input wire logic test_pll_rst_n_pin,
  input wire logic clamp_filter_pin,
  input wire logic [1:0] pll_char_out,
  input wire logic pll_clamp_filter,
  input wire logic wmr_prepare,
  input wire logic cluster_hold_n,
  input wire logic io_phase,
  input wire logic io_half_rate_clock,
  input wire logic ref_core_sync,
  input wire logic core_ref_sync,
  input wire logic sync_stable,
  input wire logic [5:0] feedback_divider,
  input wire logic [7:0] mem_divider,
  input wire logic pll_in_reset
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  // Pins cross two sync flops and an output flop, so four steady cycles are enough.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  pll_hold_a: assert property (!pll_rst_n [*4] |=> pll_in_reset)
    else $error("pll left reset while reset low");
  stable_lock_a: assert property (sync_stable |-> !pll_in_reset)
    else $error("stable while pll in reset");
  wmr_drop_a: assert property (wmr_prepare [*4] |=> !sync_stable)
    else $error("stable kept during warm reset prep");
  char_idle_a: assert property (!test_mode_pin [*4] |=> pll_char_out == 2'b00)
    else $error("char output active outside test mode");
  fb_pin_a: assert property ((test_mode_pin && $stable(test_feedback_divider_in)) [*4] |=>
    feedback_divider == (($past(test_feedback_divider_in) < FB_DIV_MIN) ? FB_DIV_MIN :
    $past(test_feedback_divider_in)))
    else $error("feedback divider not from pins");
  mem_pin_a: assert property ((test_mode_pin && $stable(test_mem_divider_in)) [*4] |=>
    mem_divider == $past(test_mem_divider_in)) else $error("memory divider not from pins");
  clamp_pin_a: assert property ((test_mode_pin && $stable(clamp_filter_pin)) [*4] |=>
    pll_clamp_filter == $past(clamp_filter_pin)) else $error("clamp not from pin");
  test_rst_a: assert property ((test_mode_pin && !test_pll_rst_n_pin) [*4] |=> pll_in_reset)
    else $error("test reset pin ignored");
  fb_floor_a: assert property (feedback_divider >= FB_DIV_MIN)
    else $error("feedback divider below minimum");
  pulse_one_a: assert property (ref_core_sync || core_ref_sync |=> !ref_core_sync && !core_ref_sync)
    else $error("sync pulse longer than one cycle");
  hold_low_a: assert property (!cluster_hold_n [*4] |=> !io_phase && !io_half_rate_clock)
    else $error("header clock not held low");
endmodule
bind clk_ctl_unit clk_ctl_checker i_clk_ctl_checker (.*);

/* File: bench/reset_unit_model.sv */
// Model of the reset unit and test controller clock sources.
`timescale 1ns/1ps
module reset_unit_model (
  input wire logic clk,
  input wire logic por_n,
  input wire logic relock_n,
  output logic pll_rst_n,
  output logic rst_n,
  output logic ref_clock,
  output logic core_bypass_clock,
  output logic mem_bypass_clock
);
  logic [3:0] cnt_q;
  logic [2:0] div_q;
  // Count from power-on so the two resets leave at different times.
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      cnt_q <= 4'h0;
    end else if (cnt_q != 4'hf) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
  // Logic reset trails the PLL reset by four cycles.
  assign pll_rst_n = (cnt_q >= 4'h2) && relock_n;
  assign rst_n = cnt_q >= 4'h6;
  // The reference runs free; bypass clocks are separate for core and memory.
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      div_q <= 3'h0;
    end else begin
      div_q <= div_q + 3'h1;
    end
  end
  assign ref_clock = div_q[2];
  assign core_bypass_clock = div_q[0];
  assign mem_bypass_clock = div_q[1];
endmodule

/* File: bench/testbench.sv */
// Self-checking testbench for the PLL clock control unit.
`timescale 1ns/1ps
module testbench;
  import clk_ctl_pkg::*;
  localparam int LK = 20;
  logic clk = 1'b0, por_n = 1'b0, relock_n = 1'b1;
  logic rst_n, pll_rst_n, ref_clock, core_bypass_clock, mem_bypass_clock;
  logic haddr_sel = 1'b0, core_domain_stop = 1'b0, io_domain_stop = 1'b0, stop_override = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0, test_mode_pin = 1'b0, test_pll_rst_n_pin = 1'b1;
  logic clamp_filter_pin = 1'b0, clk_stretch = 1'b0, wmr_prepare = 1'b0, cluster_hold_n = 1'b1;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic [1:0] htrans = 2'h0, src_select = 2'h0, pll_char_out;
  logic [2:0] hsize = 3'h2;
  logic [5:0] test_feedback_divider_in = 6'h7, feedback_divider;
  logic [7:0] test_mem_divider_in = 8'h8, mem_divider;
  logic hready, hreadyout, hresp, pll_clamp_filter, core_clock_out, memory_clock, io_phase;
  logic io_half_rate_clock, ref_core_sync, core_ref_sync, ref_clock_buf, sync_stable, div_change, pll_in_reset;
  int bad_count = 0, n_tests = 0, tg, np, mt, rb, ih, ip;
  assign hready = hreadyout;
  always #4 clk = ~clk;
  reset_unit_model i_reset_unit_model (.*);
  clk_ctl_unit #(.LOCK_COUNT(LK)) i_clk_ctl_unit (.*);
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One single AHB transfer; the address phase is held until hready is seen.
  task automatic bus(input logic [11:0] a, input logic wr, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    check("read data", q, exp);
  endtask
  // Bounded wait for lock; a missing lock shows up in the check after it.
  task automatic lock_wait();
    for (int i = 0; i < LK + 40 && sync_stable !== 1'b1; i++) @(posedge clk);
    check("sync_stable", 32'(sync_stable), 32'h1);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    por_n <= 1'b1;
    repeat (8) @(posedge clk);
    check("fb_div", 32'(feedback_divider), 32'h7);
    check("mem_div", 32'(mem_divider), 32'h8);
    rd(PLL_CFG_OFFSET, PLL_CFG_RESET);
    rd(CTRL_OFFSET, 32'h0);
    bus(12'h00c, 1'b1, 32'hffff_ffff);
    rd(12'h00c, 32'h0);
    $display("test reset values done");
    lock_wait();
    check("in_reset", 32'(pll_in_reset), 32'h0);
    rd(STATUS_OFFSET, 32'h3);
    relock_n <= 1'b0;
    repeat (8) @(posedge clk);
    check("in_reset", 32'(pll_in_reset), 32'h1);
    check("stable", 32'(sync_stable), 32'h0);
    relock_n <= 1'b1;
    lock_wait();
    $display("test lock done");
    bus(PLL_CFG_OFFSET, 1'b1, 32'h0001_0a14);
    repeat (3) @(posedge clk);
    check("fb_div", 32'(feedback_divider), 32'h14);
    check("mem_div", 32'(mem_divider), 32'h0a);
    check("change", 32'(div_change), 32'h1);
    rd(PLL_CFG_OFFSET, 32'h0001_0a14);
    bus(PLL_CFG_OFFSET, 1'b1, 32'h0000_0803);
    bus(CTRL_OFFSET, 1'b1, 32'h1);
    repeat (3) @(posedge clk);
    check("fb_div", 32'(feedback_divider), 32'h7);
    check("change", 32'(div_change), 32'h0);
    check("clamp", 32'(pll_clamp_filter), 32'h1);
    $display("test dividers done");
    test_mode_pin <= 1'b1;
    test_feedback_divider_in <= 6'h09;
    test_mem_divider_in <= 8'h15;
    repeat (6) @(posedge clk);
    check("fb_div", 32'(feedback_divider), 32'h9);
    check("mem_div", 32'(mem_divider), 32'h15);
    check("clamp", 32'(pll_clamp_filter), 32'h0);
    check("char", 32'(pll_char_out), 32'h2);
    rd(STATUS_OFFSET, 32'h7);
    test_pll_rst_n_pin <= 1'b0;
    repeat (6) @(posedge clk);
    check("in_reset", 32'(pll_in_reset), 32'h1);
    test_pll_rst_n_pin <= 1'b1;
    test_mode_pin <= 1'b0;
    repeat (6) @(posedge clk);
    check("char", 32'(pll_char_out), 32'h0);
    check("fb_div", 32'(feedback_divider), 32'h7);
    lock_wait();
    $display("test pin mode done");
    wmr_prepare <= 1'b1;
    repeat (6) @(posedge clk);
    check("stable", 32'(sync_stable), 32'h0);
    rd(STATUS_OFFSET, 32'hb);
    wmr_prepare <= 1'b0;
    $display("test warm prep done");
    for (int s = 0; s < 4; s++) begin
      src_select <= 2'(s);
      clk_stretch <= (s == 3);
      repeat (8) @(posedge clk);
      tg = 0;
      np = 0;
      mt = 0;
      rb = 0;
      ih = 0;
      ip = 0;
      q[4:0] = {io_phase, io_half_rate_clock, ref_clock_buf, memory_clock, core_clock_out};
      repeat (64) begin
        @(posedge clk);
        tg += int'(core_clock_out !== q[0]);
        mt += int'(memory_clock !== q[1]);
        rb += int'(ref_clock_buf === 1'b1 && q[2] === 1'b0);
        ih += int'(io_half_rate_clock !== q[3]);
        ip += int'(io_phase !== q[4]);
        np += int'(ref_core_sync === 1'b1) + int'(core_ref_sync === 1'b1);
        q[4:0] = {io_phase, io_half_rate_clock, ref_clock_buf, memory_clock, core_clock_out};
      end
      // A held stretch keeps the core and memory clocks low, so that source shows no edges on them.
      check("src toggles", 32'(tg != 0), 32'(s != 3));
      check("mem toggles", 32'(mt != 0), 32'(s != 3));
      check("ref buffer", 32'(rb), 32'h8);
      check("io half rate", 32'(ih), 32'h4);
      check("io phase", 32'(ip), 32'h2);
      check("sync pulses", 32'(np), 32'h10);
    end
    $display("test sources done");
    cluster_hold_n <= 1'b0;
    repeat (8) @(posedge clk);
    check("io clocks", {28'h0, core_clock_out, memory_clock, io_phase, io_half_rate_clock}, 32'h0);
    cluster_hold_n <= 1'b1;
    por_n <= 1'b0;
    repeat (4) @(posedge clk);
    check("fb_div", 32'(feedback_divider), 32'h7);
    check("in_reset", 32'(pll_in_reset), 32'h1);
    por_n <= 1'b1;
    $display("test hold and reset done");
    test_done();
  end
  // Watchdog: the whole sequence needs well under a thousand cycles.
  initial begin
    repeat (4000) @(posedge clk);
    bad_count++;
    test_done();
  end
endmodule
